/* File: logic/rvc_regs.vh */
`ifndef RVC_REGS_VH
`define RVC_REGS_VH

// ==========================================================================
// Register offsets
`define RVC_OFS_BUCK6_SLEEP   8'h99
`define RVC_OFS_LDO2_CODES    8'h9a
`define RVC_OFS_LDO3_CODES    8'h9b
`define RVC_OFS_BUCK123_CTRL  8'h9c

// ==========================================================================
// Field positions
`define RVC_B6_CODE_HI        7
`define RVC_B6_CODE_LO        1
`define RVC_LDO_SLP_HI        7
`define RVC_LDO_SLP_LO        4
`define RVC_LDO_NRM_HI        3
`define RVC_LDO_NRM_LO        0
`define RVC_CTRL_MODE_HI      5
`define RVC_CTRL_MODE_LO      3
`define RVC_CTRL_EN_HI        2
`define RVC_CTRL_EN_LO        0

// ==========================================================================
// Writable masks; bit 0 of the sleep register and bits 7:6 of control
`define RVC_MASK_BUCK6_SLEEP  8'hfe
`define RVC_MASK_CTRL         8'h3f

// ==========================================================================
// Reset images per factory variant (variant 0 to 3)
`define RVC_RST_B6_V0         8'hbe
`define RVC_RST_B6_V1         8'h8c
`define RVC_RST_B6_V2         8'h70
`define RVC_RST_B6_V3         8'h4c
`define RVC_RST_L2_V0         8'hff
`define RVC_RST_L2_V1         8'haa
`define RVC_RST_L2_V2         8'haa
`define RVC_RST_L2_V3         8'h00
`define RVC_RST_L3_V0         8'haa
`define RVC_RST_L3_V1         8'haa
`define RVC_RST_L3_V2         8'haa
`define RVC_RST_L3_V3         8'h00
`define RVC_RST_CT_V0         8'h27
`define RVC_RST_CT_V1         8'h27
`define RVC_RST_CT_V2         8'h3f
`define RVC_RST_CT_V3         8'h27

`endif

/* File: logic/rvc_regulator_voltage_control_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "rvc_regs.vh"

// What this block does
// - The sixth buck's sleep target comes from bits 7:1 of its sleep register.
// - LDO two's sleep code comes from bits 7:4 of its voltage register.
// - LDO two's normal code comes from bits 3:0 of that read-write register.
// - LDO three's sleep code comes from bits 7:4 of its voltage register.
// - LDO three's normal code is bits 3:0, chosen against sleep by state.
// - Control at 9Ch holds modes in bits 5:3, enables in 2:0, 7:6 reserved.
// - Every register resets to an image set by the factory variant.
// - A mode bit of 0 means automatic, 1 means forced PWM.
// - An enable bit of 0 forces its converter off whatever the pins say.
module rvc_regulator_voltage_control_regs #(
    parameter [1:0] VARIANT = 2'h0
) (
    input  wire       CLOCK,
    input  wire       RESETN,
    input  wire       WR_EN,
    input  wire [7:0] ADDR,
    input  wire [7:0] WR_DATA,
    output reg  [7:0] RD_DATA,
    output wire       ADDR_HIT,
    input  wire       SLEEP_ACTIVE,
    input  wire [2:0] PIN_REQUEST,
    output reg  [6:0] SIXTH_CONVERTER_VOLTAGE_CODE,
    output reg  [3:0] LDO_TWO_VOLTAGE_CODE,
    output reg  [3:0] LDO_THREE_VOLTAGE_CODE,
    output reg  [2:0] CONVERTER_PWM_FORCE,
    output reg  [2:0] CONVERTER_RUN
);

    // ======================================================================
    // Registers
    reg  [7:0] buck6_sleep_voltage_q;
    reg  [7:0] ldo2_voltage_codes_q;
    reg  [7:0] ldo3_voltage_codes_q;
    reg  [7:0] buck_one_to_three_control_q;
    reg  [7:0] buck6_sleep_voltage_d;
    reg  [7:0] ldo2_voltage_codes_d;
    reg  [7:0] ldo3_voltage_codes_d;
    reg  [7:0] buck_one_to_three_control_d;
    reg  [2:0] pin_s1_q;
    reg  [2:0] pin_s2_q;
    reg  [2:0] pin_s3_q;
    reg  [2:0] pin_req_q;
    reg        slp_s1_q;
    reg        slp_s2_q;
    reg        slp_s3_q;
    reg        sleep_q;
    wire [6:0] sixth_converter_sleep_voltage_code;
    wire [3:0] ldo_two_sleep_voltage_code;
    wire [3:0] ldo_two_normal_voltage_code;
    wire [3:0] ldo_three_sleep_voltage_code;
    wire [3:0] ldo_three_normal_voltage_code;
    wire [2:0] converter_pwm_force;
    wire [2:0] converter_enable;

    // Pick a reset image by variant
    function [7:0] rst_pick;
        input [1:0] v;
        input [7:0] a0;
        input [7:0] a1;
        input [7:0] a2;
        input [7:0] a3;
        begin
            case (v)
                2'h0: rst_pick = a0;
                2'h1: rst_pick = a1;
                2'h2: rst_pick = a2;
                default: rst_pick = a3;
            endcase
        end
    endfunction

    // Pick the sleep or normal half of an LDO code register
    function [3:0] ldo_code_pick;
        input       in_sleep;
        input [3:0] sleep_code;
        input [3:0] normal_code;
        begin
            if (in_sleep) begin
                ldo_code_pick = sleep_code;
            end else begin
                ldo_code_pick = normal_code;
            end
        end
    endfunction

    // Field views
    assign sixth_converter_sleep_voltage_code =
        buck6_sleep_voltage_q[`RVC_B6_CODE_HI:`RVC_B6_CODE_LO];
    assign ldo_two_sleep_voltage_code =
        ldo2_voltage_codes_q[`RVC_LDO_SLP_HI:`RVC_LDO_SLP_LO];
    assign ldo_two_normal_voltage_code =
        ldo2_voltage_codes_q[`RVC_LDO_NRM_HI:`RVC_LDO_NRM_LO];
    assign ldo_three_sleep_voltage_code =
        ldo3_voltage_codes_q[`RVC_LDO_SLP_HI:`RVC_LDO_SLP_LO];
    assign ldo_three_normal_voltage_code =
        ldo3_voltage_codes_q[`RVC_LDO_NRM_HI:`RVC_LDO_NRM_LO];
    assign converter_pwm_force =
        buck_one_to_three_control_q[`RVC_CTRL_MODE_HI:`RVC_CTRL_MODE_LO];
    assign converter_enable =
        buck_one_to_three_control_q[`RVC_CTRL_EN_HI:`RVC_CTRL_EN_LO];

    // ======================================================================
    // Register writes, variant reset images
    always @(posedge CLOCK) begin
        if (!RESETN) begin
            buck6_sleep_voltage_q <= rst_pick(VARIANT, `RVC_RST_B6_V0,
                `RVC_RST_B6_V1, `RVC_RST_B6_V2, `RVC_RST_B6_V3);
            ldo2_voltage_codes_q <= rst_pick(VARIANT, `RVC_RST_L2_V0,
                `RVC_RST_L2_V1, `RVC_RST_L2_V2, `RVC_RST_L2_V3);
            ldo3_voltage_codes_q <= rst_pick(VARIANT, `RVC_RST_L3_V0,
                `RVC_RST_L3_V1, `RVC_RST_L3_V2, `RVC_RST_L3_V3);
            buck_one_to_three_control_q <= rst_pick(VARIANT,
                `RVC_RST_CT_V0, `RVC_RST_CT_V1, `RVC_RST_CT_V2,
                `RVC_RST_CT_V3);
        end else begin
            buck6_sleep_voltage_q       <= buck6_sleep_voltage_d;
            ldo2_voltage_codes_q        <= ldo2_voltage_codes_d;
            ldo3_voltage_codes_q        <= ldo3_voltage_codes_d;
            buck_one_to_three_control_q <= buck_one_to_three_control_d;
        end
    end

    // Next values: hold, unless a write strobe selects the register
    always @* begin
        buck6_sleep_voltage_d       = buck6_sleep_voltage_q;
        ldo2_voltage_codes_d        = ldo2_voltage_codes_q;
        ldo3_voltage_codes_d        = ldo3_voltage_codes_q;
        buck_one_to_three_control_d = buck_one_to_three_control_q;
        if (WR_EN) begin
            case (ADDR)
                `RVC_OFS_BUCK6_SLEEP: begin
                    // Bit 0 is reserved and stays zero
                    buck6_sleep_voltage_d =
                        WR_DATA & `RVC_MASK_BUCK6_SLEEP;
                end
                `RVC_OFS_LDO2_CODES: begin
                    ldo2_voltage_codes_d = WR_DATA;
                end
                `RVC_OFS_LDO3_CODES: begin
                    ldo3_voltage_codes_d = WR_DATA;
                end
                `RVC_OFS_BUCK123_CTRL: begin
                    // Bits 7:6 are reserved and stay zero
                    buck_one_to_three_control_d =
                        WR_DATA & `RVC_MASK_CTRL;
                end
                default: begin
                    // Unmapped offsets change nothing
                end
            endcase
        end
    end

    // ======================================================================
    // Read mux; unmapped offsets read zero
    assign ADDR_HIT = (ADDR == `RVC_OFS_BUCK6_SLEEP) ||
                      (ADDR == `RVC_OFS_LDO2_CODES) ||
                      (ADDR == `RVC_OFS_LDO3_CODES) ||
                      (ADDR == `RVC_OFS_BUCK123_CTRL);

    always @* begin
        case (ADDR)
            `RVC_OFS_BUCK6_SLEEP:  RD_DATA = buck6_sleep_voltage_q;
            `RVC_OFS_LDO2_CODES:   RD_DATA = ldo2_voltage_codes_q;
            `RVC_OFS_LDO3_CODES:   RD_DATA = ldo3_voltage_codes_q;
            `RVC_OFS_BUCK123_CTRL: RD_DATA = buck_one_to_three_control_q;
            default:               RD_DATA = 8'h00;
        endcase
    end

    // ======================================================================
    // Pin synchronisers: a change counts once stages two and three agree
    always @(posedge CLOCK) begin
        if (!RESETN) begin
            pin_s1_q  <= 3'h0;
            pin_s2_q  <= 3'h0;
            pin_s3_q  <= 3'h0;
            pin_req_q <= 3'h0;
            slp_s1_q  <= 1'b0;
            slp_s2_q  <= 1'b0;
            slp_s3_q  <= 1'b0;
            sleep_q   <= 1'b0;
        end else begin
            pin_s1_q <= PIN_REQUEST;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_req_q <= (pin_s2_q & pin_s3_q) |
                         (pin_req_q & (pin_s2_q | pin_s3_q));
            slp_s1_q <= SLEEP_ACTIVE;
            slp_s2_q <= slp_s1_q;
            slp_s3_q <= slp_s2_q;
            if (slp_s2_q == slp_s3_q) begin
                sleep_q <= slp_s3_q;
            end
        end
    end

    // ======================================================================
    // Regulator outputs, registered
    always @(posedge CLOCK) begin
        if (!RESETN) begin
            SIXTH_CONVERTER_VOLTAGE_CODE <= 7'h00;
            LDO_TWO_VOLTAGE_CODE         <= 4'h0;
            LDO_THREE_VOLTAGE_CODE       <= 4'h0;
            CONVERTER_PWM_FORCE          <= 3'h0;
            CONVERTER_RUN                <= 3'h0;
        end else begin
            SIXTH_CONVERTER_VOLTAGE_CODE <=
                sixth_converter_sleep_voltage_code;
            LDO_TWO_VOLTAGE_CODE <= ldo_code_pick(sleep_q,
                ldo_two_sleep_voltage_code,
                ldo_two_normal_voltage_code);
            LDO_THREE_VOLTAGE_CODE <= ldo_code_pick(sleep_q,
                ldo_three_sleep_voltage_code,
                ldo_three_normal_voltage_code);
            CONVERTER_PWM_FORCE <= converter_pwm_force;
            CONVERTER_RUN <= pin_req_q & converter_enable;
        end
    end

endmodule // rvc_regulator_voltage_control_regs
`default_nettype wire

/* File: verification/rvc_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ==============================================
// Register bank checker
module rvc_regs_props (
    input wire logic       CLOCK, RESETN, WR_EN, ADDR_HIT, SLEEP_ACTIVE,
    input wire logic [7:0] ADDR, WR_DATA, RD_DATA,
    input wire logic [2:0] PIN_REQUEST, CONVERTER_PWM_FORCE, CONVERTER_RUN,
    input wire logic [6:0] SIXTH_CONVERTER_VOLTAGE_CODE,
    input wire logic [3:0] LDO_TWO_VOLTAGE_CODE, LDO_THREE_VOLTAGE_CODE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // Read path, decode and reserved bits
    AST_CTRL_RSV: assert property (ADDR == 8'h9c |-> RD_DATA[7:6] == 2'h0)
        else $error("control reserved bits not zero");
    AST_B6_RSV: assert property (ADDR == 8'h99 |-> !RD_DATA[0])
        else $error("sleep register bit 0 not zero");
    AST_HIT: assert property (ADDR_HIT == (ADDR >= 8'h99 && ADDR <= 8'h9c))
        else $error("address decode wrong");
    AST_CTRL_WR: assert property ((WR_EN && ADDR == 8'h9c) ##1 ADDR == 8'h9c
        |-> RD_DATA == {2'h0, $past(WR_DATA[5:0])}) else $error("control write");
    // Outputs follow the registers one edge later
    AST_SIX: assert property (WR_EN && ADDR == 8'h99 |-> ##2
        SIXTH_CONVERTER_VOLTAGE_CODE == $past(WR_DATA[7:1], 2))
        else $error("sleep code output wrong");
    AST_PWM: assert property (WR_EN && ADDR == 8'h9c |-> ##2
        CONVERTER_PWM_FORCE == $past(WR_DATA[5:3], 2)) else $error("pwm force");
    AST_RUN_OFF: assert property (WR_EN && ADDR == 8'h9c |-> ##2
        (CONVERTER_RUN & ~$past(WR_DATA[2:0], 2)) == 3'h0)
        else $error("disabled converter runs");
    AST_LDO2_SLP: assert property ((SLEEP_ACTIVE && ADDR == 8'h9a && !WR_EN)[*8]
        |-> LDO_TWO_VOLTAGE_CODE == RD_DATA[7:4]) else $error("ldo two sleep");
    AST_LDO3_NRM: assert property ((!SLEEP_ACTIVE && ADDR == 8'h9b && !WR_EN)[*8]
        |-> LDO_THREE_VOLTAGE_CODE == RD_DATA[3:0]) else $error("ldo three");
    // Main scenarios
    cover property (WR_EN && ADDR == 8'h9c);
    cover property ((SLEEP_ACTIVE && ADDR == 8'h9a && !WR_EN)[*8]);
    cover property (CONVERTER_RUN != 3'h0);
endmodule // rvc_regs_props
bind rvc_regulator_voltage_control_regs rvc_regs_props rvc_regs_props_inst (
    .CLOCK(CLOCK), .RESETN(RESETN), .WR_EN(WR_EN), .ADDR_HIT(ADDR_HIT),
    .SLEEP_ACTIVE(SLEEP_ACTIVE), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .RD_DATA(RD_DATA), .PIN_REQUEST(PIN_REQUEST),
    .CONVERTER_PWM_FORCE(CONVERTER_PWM_FORCE), .CONVERTER_RUN(CONVERTER_RUN),
    .SIXTH_CONVERTER_VOLTAGE_CODE(SIXTH_CONVERTER_VOLTAGE_CODE),
    .LDO_TWO_VOLTAGE_CODE(LDO_TWO_VOLTAGE_CODE),
    .LDO_THREE_VOLTAGE_CODE(LDO_THREE_VOLTAGE_CODE));
`default_nettype wire

/* File: verification/rvc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Management host: drives the register bus at the falling edge
module rvc_host_model (
    input  wire logic       CLOCK,
    input  wire logic [7:0] RD_DATA,
    output var logic        WR_EN = 1'b0,
    output var logic [7:0]  ADDR = 8'h00,
    output var logic [7:0]  WR_DATA = 8'h00
);
    // One-cycle write strobe; data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLOCK);
        ADDR = a;
        WR_DATA = d;
        WR_EN = 1'b1;
        @(negedge CLOCK);
        WR_EN = 1'b0;
        WR_DATA = ~d;
    endtask
    // Combinational read, sampled once the address has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge CLOCK);
        ADDR = a;
        #1 d = RD_DATA;
    endtask
endmodule // rvc_host_model
`default_nettype wire

/* File: verification/rvc_regulator_voltage_control_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rvc_regulator_voltage_control_regs_tb_top;
    logic       CLOCK = 1'b0, RESETN = 1'b0, SLEEP_ACTIVE = 1'b0;
    logic [2:0] PIN_REQUEST = 3'h0;
    wire logic       WR_EN, ADDR_HIT;
    wire logic [7:0] ADDR, WR_DATA, RD_DATA;
    wire logic [6:0] six;
    wire logic [3:0] l2, l3;
    wire logic [2:0] pwm, run;
    int fail_count = 0, samples_checked = 0;
    logic [7:0] v, mir [4];
    logic [7:0] rst [4] = '{8'hbe, 8'hff, 8'haa, 8'h27};
    logic [7:0] msk [4] = '{8'hfe, 8'hff, 8'hff, 8'h3f};
    always #10 CLOCK = ~CLOCK;
    rvc_host_model host (.CLOCK(CLOCK), .RD_DATA(RD_DATA), .WR_EN(WR_EN),
        .ADDR(ADDR), .WR_DATA(WR_DATA));
    rvc_regulator_voltage_control_regs rvc_regulator_voltage_control_regs_inst (
        .CLOCK(CLOCK), .RESETN(RESETN), .WR_EN(WR_EN), .ADDR(ADDR),
        .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .ADDR_HIT(ADDR_HIT),
        .SLEEP_ACTIVE(SLEEP_ACTIVE), .PIN_REQUEST(PIN_REQUEST),
        .SIXTH_CONVERTER_VOLTAGE_CODE(six), .LDO_TWO_VOLTAGE_CODE(l2),
        .LDO_THREE_VOLTAGE_CODE(l3), .CONVERTER_PWM_FORCE(pwm),
        .CONVERTER_RUN(run));
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        #200000;
        fail_count++;
        wrap_up;
    end
    // Reset images, then random writes with all-zero and all-one corners
    initial begin
        v = 8'($urandom(12012));
        repeat (6) @(negedge CLOCK);
        RESETN = 1'b1;
        for (int i = 0; i < 5; i++) begin
            host.rd(8'(8'h99 + i), v);
            chk(v, i < 4 ? rst[i] : 8'h00);
        end
        mir = rst;
        for (int n = 0; n < 40; n++) begin
            SLEEP_ACTIVE = n[0];
            PIN_REQUEST = 3'($urandom);
            for (int i = 0; i < 5; i++) begin
                v = n < 2 ? {8{n[0]}} : 8'($urandom);
                host.wr(8'(8'h99 + i), v);
                if (i < 4) mir[i] = v & msk[i];
            end
            host.rd(n[0] ? 8'h9a : 8'h9b, v);
            repeat (8) @(negedge CLOCK);
            for (int i = 0; i < 5; i++) begin
                host.rd(8'(8'h99 + i), v);
                chk(v, i < 4 ? mir[i] : 8'h00);
                chk({7'h0, ADDR_HIT}, {7'h0, i < 4});
            end
            chk({1'b0, six}, {1'b0, mir[0][7:1]});
            chk({4'h0, l2}, {4'h0, n[0] ? mir[1][7:4] : mir[1][3:0]});
            chk({4'h0, l3}, {4'h0, n[0] ? mir[2][7:4] : mir[2][3:0]});
            chk({5'h0, pwm}, {5'h0, mir[3][5:3]});
            chk({5'h0, run}, {5'h0, PIN_REQUEST & mir[3][2:0]});
        end
        wrap_up;
    end
endmodule // rvc_regulator_voltage_control_regs_tb_top
`default_nettype wire
